// File: logic/tof_camera_config_status_regs.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tof_camera_config_status_regs #(
    parameter int TICK_CYCLES = tof_regs_pkg::TICK_CYCLES,
    parameter int ADDR_W      = 8
) (
    // Clock and reset.
    input  wire logic                      CLK,
    input  wire logic                      RSTN,
    // APB slave.
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [ADDR_W-1:0]         PADDR,
    input  wire logic [31:0]               PWDATA,
    input  wire logic [3:0]                PSTRB,
    output var  logic [31:0]               PRDATA,
    output var  logic                      PREADY,
    output var  logic                      PSLVERR,
    // Device status sources.
    input  wire logic [31:0]               SERIAL_NUMBER,
    input  wire logic                      FRAME_START,
    input  wire logic                      FRAME_DONE,
    input  wire logic [15:0]               EMITTER_TEMP,
    input  wire logic                      EMITTER_TEMP_OK,
    input  wire logic [15:0]               MAIN_TEMP,
    input  wire logic                      MAIN_TEMP_OK,
    input  wire tof_regs_pkg::cal_status_t CAL_STATUS,
    input  wire logic                      STORED_ILLUM_ALT,
    // Pixel check.
    input  wire logic [15:0]               PIXEL_AMP,
    input  wire logic                      PIXEL_AMP_VALID,
    output var  logic                      DIST_VALID,
    // Controls.
    output var  tof_regs_pkg::mode_ctrl_t  MODE,
    output var  logic [15:0]               LINEAR_AMPLITUDE,
    output var  logic [15:0]               LINEAR_PHASE,
    output var  logic                      OVER_TEMP,
    output var  logic                      CAL_START,
    output var  logic                      FLASH_SAVE,
    output var  logic                      TEST_UNLOCK
);
    import tof_regs_pkg::*;

    // Elaboration stops on parameter values that the logic cannot serve.
    if (TICK_CYCLES < 1 || ADDR_W < 8 || ADDR_W > 32) begin
        $error("Unsupported parameter value.");
    end

    logic [15:0] frame_tally;
    logic [15:0] cal_request;
    logic [15:0] amp_low;
    logic [15:0] amp_high;
    logic [15:0] feature;
    logic [15:0] proc_time;
    logic [15:0] emit_temp;
    logic [15:0] main_temp;
    logic [15:0] temp_limit;
    logic [15:0] cal_progress;
    logic [15:0] cal_target;
    logic [15:0] unlock_key;
    logic [15:0] cmd_exec;
    logic        illum_loaded;
    logic [31:0] proc_pre;
    logic [15:0] proc_cnt;
    logic [31:0] ival_pre;
    logic [15:0] ival_cnt;
    logic [15:0] frame_ival;
    logic [15:0] next_rdata;
    logic        hit;
    logic        access;
    logic        wr_en;
    logic [5:0]  idx;

    function automatic logic [15:0] merge(input logic [15:0] old_value,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  strb);
        merge = {strb[1] ? wdata[15:8] : old_value[15:8],
                 strb[0] ? wdata[7:0]  : old_value[7:0]};
    endfunction

    // Misaligned or out-of-range addresses answer with an error.
    assign idx    = PADDR[7:2];
    assign access = PSEL && PENABLE && PREADY;
    assign wr_en  = access && PWRITE && !PSLVERR;

    always_comb begin
        hit        = 1'b1;
        next_rdata = 16'h0000;
        case (idx)
            IDX_SERIAL_LOW:   next_rdata = SERIAL_NUMBER[15:0];
            IDX_SERIAL_HIGH:  next_rdata = SERIAL_NUMBER[31:16];
            IDX_FRAME_TALLY:  next_rdata = frame_tally;
            IDX_CAL_REQUEST:  next_rdata = cal_request;
            IDX_AMP_LOW:      next_rdata = amp_low;
            IDX_AMP_HIGH:     next_rdata = amp_high;
            IDX_FEATURE:      next_rdata = feature;
            IDX_PROC_TIME:    next_rdata = proc_time;
            IDX_EMIT_TEMP:    next_rdata = emit_temp;
            IDX_MAIN_TEMP:    next_rdata = main_temp;
            IDX_LIN_AMP:      next_rdata = LINEAR_AMPLITUDE;
            IDX_LIN_PHASE:    next_rdata = LINEAR_PHASE;
            IDX_FRAME_IVAL:   next_rdata = frame_ival;
            IDX_CAL_PROGRESS: next_rdata = cal_progress;
            IDX_CAL_TARGET:   next_rdata = cal_target;
            IDX_UNLOCK_KEY:   next_rdata = unlock_key;
            IDX_TEMP_LIMIT:   next_rdata = temp_limit;
            IDX_CMD_EXEC:     next_rdata = cmd_exec;
            default:          hit = 1'b0;
        endcase
        if (PADDR[1:0] != 2'b00 || (ADDR_W > 8 && (PADDR >> 8) != '0)) begin
            hit = 1'b0;
        end
    end

    // One wait state lets the answer come straight from flip-flops.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && !hit;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA <= {16'h0000, hit ? next_rdata : 16'h0000};
            end
        end
    end

    // Writable registers; read-only indices have no write path at all.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cal_request      <= RST_CAL_REQUEST;
            amp_low          <= RST_AMP_LOW;
            amp_high         <= RST_AMP_HIGH;
            feature          <= RST_FEATURE;
            LINEAR_AMPLITUDE <= RST_LIN_AMP;
            LINEAR_PHASE     <= RST_LIN_PHASE;
            unlock_key       <= RST_UNLOCK_KEY;
            temp_limit       <= RST_TEMP_LIMIT;
            cmd_exec         <= RST_CMD_EXEC;
            illum_loaded     <= 1'b0;
        end else begin
            illum_loaded <= 1'b1;
            if (!illum_loaded) begin
                feature[FEAT_ILLUM_ALT] <= STORED_ILLUM_ALT;
            end else if (wr_en) begin
                case (idx)
                    IDX_CAL_REQUEST: cal_request      <= merge(cal_request, PWDATA, PSTRB);
                    IDX_AMP_LOW:     amp_low          <= merge(amp_low, PWDATA, PSTRB);
                    IDX_AMP_HIGH:    amp_high         <= merge(amp_high, PWDATA, PSTRB);
                    IDX_FEATURE:     feature          <= merge(feature, PWDATA, PSTRB);
                    IDX_LIN_AMP:     LINEAR_AMPLITUDE <= merge(LINEAR_AMPLITUDE, PWDATA, PSTRB);
                    IDX_LIN_PHASE:   LINEAR_PHASE     <= merge(LINEAR_PHASE, PWDATA, PSTRB);
                    IDX_UNLOCK_KEY:  unlock_key       <= merge(unlock_key, PWDATA, PSTRB);
                    IDX_TEMP_LIMIT:  temp_limit       <= merge(temp_limit, PWDATA, PSTRB);
                    IDX_CMD_EXEC:    cmd_exec         <= merge(cmd_exec, PWDATA, PSTRB);
                    default:         cmd_exec         <= cmd_exec;
                endcase
            end
        end
    end

    // Command pulses decode the write cycle: CAL_START from the low byte alone, FLASH_SAVE from the full 16-bit value.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CAL_START   <= 1'b0;
            FLASH_SAVE  <= 1'b0;
            TEST_UNLOCK <= 1'b0;
        end else begin
            CAL_START   <= wr_en && idx == IDX_CAL_REQUEST && PSTRB[0]
                           && PWDATA[7:0] == CAL_CMD_OFFSET;
            FLASH_SAVE  <= wr_en && idx == IDX_CMD_EXEC && PSTRB[1:0] == 2'b11
                           && PWDATA[15:0] == CMD_SAVE_MAP
                           && unlock_key == KEY_FLASH_OPS;
            TEST_UNLOCK <= unlock_key == KEY_TEST_CMDS;
        end
    end

    // The illumination select is frozen after the load that follows reset.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            MODE <= '0;
        end else begin
            MODE.auto_exposure      <= feature[FEAT_AUTO_EXPOSURE];
            MODE.extreme_value_calc <= feature[FEAT_EXTREME_CALC];
            MODE.status_light_off   <= feature[FEAT_LIGHT_OFF];
            MODE.sliding_median     <= feature[FEAT_SLIDING_MED];
            if (!illum_loaded) begin
                MODE.illum_alt <= STORED_ILLUM_ALT;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            DIST_VALID <= 1'b0;
            OVER_TEMP  <= 1'b0;
        end else begin
            DIST_VALID <= PIXEL_AMP_VALID && PIXEL_AMP >= amp_low
                          && PIXEL_AMP <= amp_high;
            OVER_TEMP  <= EMITTER_TEMP_OK && EMITTER_TEMP > temp_limit;
        end
    end

    // Status snapshots from the device side.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            frame_tally  <= 16'h0000;
            emit_temp    <= TEMP_ABSENT;
            main_temp    <= TEMP_ABSENT;
            cal_progress <= 16'h0000;
            cal_target   <= 16'h0000;
        end else begin
            if (FRAME_DONE) begin
                frame_tally <= frame_tally + 16'h0001;
            end
            emit_temp    <= EMITTER_TEMP_OK ? EMITTER_TEMP : TEMP_ABSENT;
            main_temp    <= MAIN_TEMP_OK ? MAIN_TEMP : TEMP_ABSENT;
            cal_progress <= '0;
            cal_progress[7:0] <= CAL_STATUS.code;
            cal_progress[PROG_ERROR]      <= CAL_STATUS.code >= CAL_ERR_HW;
            cal_progress[PROG_NOISE_MISS_A] <= CAL_STATUS.noise_missing;
            cal_progress[PROG_NOISE_MISS_B] <= CAL_STATUS.noise_missing;
            cal_progress[PROG_LENS_MISS]  <= CAL_STATUS.lens_missing;
            cal_progress[PROG_TEMP_COMP]  <= CAL_STATUS.temp_comp_err;
            cal_target   <= CAL_STATUS.target_mm;
        end
    end

    // Tick counters saturate rather than wrap so a stalled pipeline reads large.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            proc_pre  <= 32'h0000_0000;
            proc_cnt  <= 16'h0000;
            proc_time <= 16'h0000;
        end else if (FRAME_START) begin
            proc_pre <= 32'h0000_0000;
            proc_cnt <= 16'h0000;
        end else if (FRAME_DONE) begin
            // A tick that ends on the done edge still counts toward the result.
            if (proc_pre == 32'(TICK_CYCLES - 1) && proc_cnt != 16'hffff) begin
                proc_time <= proc_cnt + 16'h0001;
            end else begin
                proc_time <= proc_cnt;
            end
        end else if (proc_pre == 32'(TICK_CYCLES - 1)) begin
            proc_pre <= 32'h0000_0000;
            if (proc_cnt != 16'hffff) begin
                proc_cnt <= proc_cnt + 16'h0001;
            end
        end else begin
            proc_pre <= proc_pre + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ival_pre   <= 32'h0000_0000;
            ival_cnt   <= 16'h0000;
            frame_ival <= 16'h0000;
        end else if (FRAME_DONE) begin
            ival_pre   <= 32'h0000_0000;
            ival_cnt   <= 16'h0000;
            if (ival_pre == 32'(TICK_CYCLES - 1) && ival_cnt != 16'hffff) begin
                frame_ival <= ival_cnt + 16'h0001;
            end else begin
                frame_ival <= ival_cnt;
            end
        end else if (ival_pre == 32'(TICK_CYCLES - 1)) begin
            ival_pre <= 32'h0000_0000;
            if (ival_cnt != 16'hffff) begin
                ival_cnt <= ival_cnt + 16'h0001;
            end
        end else begin
            ival_pre <= ival_pre + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence apb_write_seq(logic [5:0] i);
        wr_en && idx == i;
    endsequence

    sequence read_access_seq;
        PSEL && PENABLE && !PREADY && !PWRITE;
    endsequence

    tally_increment_a: assert property (
        FRAME_DONE |=> frame_tally == $past(frame_tally) + 16'h0001)
        else $error("Frame tally did not advance.");
    serial_read_a: assert property (
        read_access_seq ##0 (idx == IDX_SERIAL_HIGH && PADDR[1:0] == 2'b00)
        |=> PREADY && PRDATA[15:0] == $past(SERIAL_NUMBER[31:16]))
        else $error("Serial high word read wrong.");
    cal_start_a: assert property (
        apb_write_seq(IDX_CAL_REQUEST) ##0 (PSTRB[0] && PWDATA[7:0] == CAL_CMD_OFFSET)
        |=> CAL_START ##1 !CAL_START)
        else $error("Calibration start pulse wrong.");
    dist_valid_a: assert property (
        PIXEL_AMP_VALID && PIXEL_AMP < amp_low |=> !DIST_VALID)
        else $error("Low amplitude marked valid.");
    exposure_follow_a: assert property (
        apb_write_seq(IDX_FEATURE) ##0 PSTRB[0]
        |=> ##1 MODE.auto_exposure == $past(PWDATA[3], 2))
        else $error("Exposure mode not applied.");
    illum_hold_a: assert property (
        illum_loaded && $past(illum_loaded) |-> $stable(MODE.illum_alt))
        else $error("Illumination select changed while running.");
    temp_absent_a: assert property (
        !MAIN_TEMP_OK |=> main_temp == TEMP_ABSENT)
        else $error("Absent sensor not all ones.");
    cal_error_a: assert property (
        CAL_STATUS.code >= CAL_ERR_HW |=> cal_progress[PROG_ERROR])
        else $error("Error flag not set.");
    save_gate_a: assert property (
        FLASH_SAVE |-> $past(unlock_key) == KEY_FLASH_OPS && $past(wr_en))
        else $error("Save without unlock key.");
    ro_write_a: assert property (
        apb_write_seq(IDX_FRAME_TALLY) ##0 !FRAME_DONE |=> $stable(frame_tally))
        else $error("Read-only register changed by write.");

endmodule
`default_nettype wire

// File: logic/tof_regs_pkg.sv
// Functional notes
// - Frame tally counts up per captured frame.
// - Serial number split low word, high word.
// - Calibration code 19 starts distance offset calibration.
// - Distance valid only between amplitude thresholds.
// - Feature bit 3 switches automatic exposure.
// - Feature bit 7 enables extreme value calculation.
// - Feature bit 8 turns status light off.
// - Feature bit 11 enables sliding median.
// - Illumination select applies only after reset.
// - Processing duration reported in 100 us units.
// - Temperatures in 0.01 C, all ones if absent.
// - Linearization parameters scaled, documented reset values.
// - Frame interval reported in 0.1 ms units.
// - Progress low byte carries status and error codes.
// - Error flag bit 10, missing-data flags above.
// - Calibration target distance reported in millimetres.
// - Unlock key gates flash and test commands.
// - Writable emitter temperature limit, reset 0x2328.
// - Save command 0xdd9e works only when unlocked.
`default_nettype none
package tof_regs_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [5:0] IDX_SERIAL_LOW   = 6'h0c;
    localparam logic [5:0] IDX_SERIAL_HIGH  = 6'h0d;
    localparam logic [5:0] IDX_FRAME_TALLY  = 6'h0e;
    localparam logic [5:0] IDX_CAL_REQUEST  = 6'h0f;
    localparam logic [5:0] IDX_AMP_LOW      = 6'h10;
    localparam logic [5:0] IDX_AMP_HIGH     = 6'h11;
    localparam logic [5:0] IDX_FEATURE      = 6'h19;
    localparam logic [5:0] IDX_PROC_TIME    = 6'h1a;
    localparam logic [5:0] IDX_EMIT_TEMP    = 6'h1b;
    localparam logic [5:0] IDX_MAIN_TEMP    = 6'h1c;
    localparam logic [5:0] IDX_LIN_AMP      = 6'h1d;
    localparam logic [5:0] IDX_LIN_PHASE    = 6'h1e;
    localparam logic [5:0] IDX_FRAME_IVAL   = 6'h1f;
    localparam logic [5:0] IDX_CAL_PROGRESS = 6'h20;
    localparam logic [5:0] IDX_CAL_TARGET   = 6'h21;
    localparam logic [5:0] IDX_UNLOCK_KEY   = 6'h22;
    localparam logic [5:0] IDX_TEMP_LIMIT   = 6'h24;
    localparam logic [5:0] IDX_CMD_EXEC     = 6'h33;

    // Reset values.
    localparam logic [15:0] RST_CAL_REQUEST = 16'h0000;
    localparam logic [15:0] RST_AMP_LOW     = 16'h012c;
    localparam logic [15:0] RST_AMP_HIGH    = 16'h3a98;
    localparam logic [15:0] RST_FEATURE     = 16'h0800;
    localparam logic [15:0] RST_LIN_AMP     = 16'h0190;
    localparam logic [15:0] RST_LIN_PHASE   = 16'h1b58;
    localparam logic [15:0] RST_UNLOCK_KEY  = 16'h0000;
    localparam logic [15:0] RST_TEMP_LIMIT  = 16'h2328;
    localparam logic [15:0] RST_CMD_EXEC    = 16'h0000;
    localparam logic [15:0] TEMP_ABSENT     = 16'hffff;

    // Feature control bit positions.
    localparam int FEAT_AUTO_EXPOSURE = 3;
    localparam int FEAT_EXTREME_CALC  = 7;
    localparam int FEAT_LIGHT_OFF     = 8;
    localparam int FEAT_SLIDING_MED   = 11;
    localparam int FEAT_ILLUM_ALT     = 12;

    // Calibration progress bit positions and codes.
    localparam int PROG_ERROR        = 10;
    localparam int PROG_NOISE_MISS_A = 11;
    localparam int PROG_NOISE_MISS_B = 12;
    localparam int PROG_LENS_MISS    = 14;
    localparam int PROG_TEMP_COMP    = 15;
    localparam logic [7:0] CAL_IDLE        = 8'h00;
    localparam logic [7:0] CAL_ERASING     = 8'h14;
    localparam logic [7:0] CAL_DONE        = 8'ha1;
    localparam logic [7:0] CAL_ERR_GENERIC = 8'hff;
    localparam logic [7:0] CAL_ERR_HW      = 8'hf7;
    localparam logic [7:0] CAL_CMD_OFFSET  = 8'h13;

    // Keys and commands.
    localparam logic [15:0] KEY_FLASH_OPS = 16'h4877;
    localparam logic [15:0] KEY_TEST_CMDS = 16'h5e6b;
    localparam logic [15:0] CMD_SAVE_MAP  = 16'hdd9e;

    // Timing: one tick is 100 us, equal to 0.1 ms.
    localparam int TICK_US      = 100;
    localparam int CLK_MHZ      = 100;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;

    typedef struct packed {
        logic [15:0] target_mm;
        logic [7:0]  code;
        logic        noise_missing;
        logic        lens_missing;
        logic        temp_comp_err;
    } cal_status_t;

    typedef struct packed {
        logic auto_exposure;
        logic extreme_value_calc;
        logic status_light_off;
        logic sliding_median;
        logic illum_alt;
    } mode_ctrl_t;

endpackage
`default_nettype wire

// File: verif/host_bus.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus (
    // Clock.
    input  wire logic        clk,
    // Request to the register bank.
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    // Answer from the register bank.
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
    end

    // The request is held until pready is seen high; only the bench watchdog ends a wait.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hf;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask
endmodule
`default_nettype wire

// File: verif/tof_camera_config_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module tof_camera_config_status_regs_test;
    import tof_regs_pkg::*;
    localparam int TICKS = 4;
    logic CLK = 0, RSTN = 0, FRAME_START = 0, FRAME_DONE = 0, STORED_ILLUM_ALT = 1;
    logic EMITTER_TEMP_OK = 0, MAIN_TEMP_OK = 0, PIXEL_AMP_VALID = 0;
    logic [31:0] SERIAL_NUMBER = 32'h0;
    logic [15:0] EMITTER_TEMP = 16'h0, MAIN_TEMP = 16'h0, PIXEL_AMP = 16'h0;
    cal_status_t CAL_STATUS = '0;
    logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DIST_VALID, OVER_TEMP;
    logic        CAL_START, FLASH_SAVE, TEST_UNLOCK;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0]  PSTRB;
    logic [15:0] LINEAR_AMPLITUDE, LINEAR_PHASE, v;
    mode_ctrl_t  MODE;
    int miscompares = 0, tests_run = 0, seed = 67, cal_pulses = 0, save_pulses = 0, tally = 0;
    int codes[12] = '{0, 20, 161, 255, 254, 253, 252, 251, 250, 249, 248, 247};
    logic [5:0] ri[9] = '{IDX_CAL_REQUEST, IDX_AMP_LOW, IDX_AMP_HIGH, IDX_FEATURE, IDX_LIN_AMP,
                          IDX_LIN_PHASE, IDX_UNLOCK_KEY, IDX_TEMP_LIMIT, IDX_CMD_EXEC};
    logic [15:0] rv[9] = '{RST_CAL_REQUEST, RST_AMP_LOW, RST_AMP_HIGH, RST_FEATURE | 16'h1000,
                           RST_LIN_AMP, RST_LIN_PHASE, RST_UNLOCK_KEY, RST_TEMP_LIMIT, RST_CMD_EXEC};

    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (CAL_START === 1'b1) cal_pulses++;
        if (FLASH_SAVE === 1'b1) save_pulses++;
    end

    tof_camera_config_status_regs #(.TICK_CYCLES(TICKS), .ADDR_W(8))
        i_tof_camera_config_status_regs (
        .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SERIAL_NUMBER(SERIAL_NUMBER), .FRAME_START(FRAME_START), .FRAME_DONE(FRAME_DONE),
        .EMITTER_TEMP(EMITTER_TEMP), .EMITTER_TEMP_OK(EMITTER_TEMP_OK), .MAIN_TEMP(MAIN_TEMP),
        .MAIN_TEMP_OK(MAIN_TEMP_OK), .CAL_STATUS(CAL_STATUS), .STORED_ILLUM_ALT(STORED_ILLUM_ALT),
        .PIXEL_AMP(PIXEL_AMP), .PIXEL_AMP_VALID(PIXEL_AMP_VALID), .DIST_VALID(DIST_VALID),
        .MODE(MODE), .LINEAR_AMPLITUDE(LINEAR_AMPLITUDE), .LINEAR_PHASE(LINEAR_PHASE),
        .OVER_TEMP(OVER_TEMP), .CAL_START(CAL_START), .FLASH_SAVE(FLASH_SAVE),
        .TEST_UNLOCK(TEST_UNLOCK));

    host_bus i_host_bus (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
        .paddr(PADDR), .pwdata(PWDATA), .pstrb(PSTRB), .prdata(PRDATA), .pready(PREADY),
        .pslverr(PSLVERR));

    task automatic chk(string nm, logic [32:0] exp, logic [32:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // The error flag rides in bit 32 so every read also checks the response code.
    task automatic rd(logic [5:0] idx, logic [15:0] exp, string nm);
        logic [31:0] r;
        logic        e;
        i_host_bus.xfer(1'b0, {idx, 2'b00}, 32'h0, r, e);
        chk(nm, {17'h0, exp}, {e, r});
    endtask
    task automatic wr(logic [5:0] idx, logic [15:0] d);
        logic [31:0] r;
        logic        e;
        i_host_bus.xfer(1'b1, {idx, 2'b00}, {16'h0, d}, r, e);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic pulse(bit start, int gap);
        @(posedge CLK);
        if (start) FRAME_START <= 1'b1;
        else FRAME_DONE <= 1'b1;
        @(posedge CLK);
        FRAME_START <= 1'b0;
        FRAME_DONE  <= 1'b0;
        repeat (gap - 2) @(posedge CLK);
    endtask

    initial begin
        #200us;
        miscompares++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        SERIAL_NUMBER = $random(seed);
        repeat (10) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (2) @(posedge CLK);
        for (int i = 0; i < 9; i++) rd(ri[i], rv[i], "reset value");
        chk("linear outputs", {1'b0, RST_LIN_AMP, RST_LIN_PHASE},
            {1'b0, LINEAR_AMPLITUDE, LINEAR_PHASE});
        rd(IDX_SERIAL_LOW, SERIAL_NUMBER[15:0], "serial low");
        rd(IDX_SERIAL_HIGH, SERIAL_NUMBER[31:16], "serial high");
        wr(IDX_SERIAL_LOW, ~SERIAL_NUMBER[15:0]);
        rd(IDX_SERIAL_LOW, SERIAL_NUMBER[15:0], "serial after write");
        i_host_bus.xfer(1'b0, 8'h48, 32'h0, r, e);
        chk("unmapped read", 33'h1_0000_0000, {e, r});
        i_host_bus.xfer(1'b0, 8'h41, 32'h0, r, e);
        chk("misaligned read", 33'h1_0000_0000, {e, r});
        $display("Done: reset values, serial number, refusals");
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            wr(IDX_FEATURE, v);
            rd(IDX_FEATURE, v, "feature readback");
            settle(2);
            chk("mode", {28'h0, v[3], v[7], v[8], v[11], 1'b1},
                {28'h0, MODE});
        end
        wr(IDX_LIN_AMP, 16'h1234);
        wr(IDX_LIN_PHASE, 16'h4321);
        settle(2);
        chk("linear written", 33'h0_1234_4321, {1'b0, LINEAR_AMPLITUDE, LINEAR_PHASE});
        $display("Done: feature control and linearization");
        wr(IDX_AMP_LOW, 16'h0200);
        wr(IDX_AMP_HIGH, 16'h0400);
        for (int i = 0; i < 24; i++) begin
            v = $random(seed) & 16'h07ff;
            e = $random(seed);
            @(posedge CLK);
            PIXEL_AMP       <= v;
            PIXEL_AMP_VALID <= e;
            settle(1);
            chk("distance valid", {32'h0, e && v >= 16'h0200 && v <= 16'h0400},
                {32'h0, DIST_VALID});
        end
        @(posedge CLK);
        PIXEL_AMP_VALID <= 1'b0;
        $display("Done: amplitude window");
        pulse(1, TICKS * 5);
        pulse(0, 2);
        tally++;
        rd(IDX_PROC_TIME, 16'd5, "processing time");
        rd(IDX_FRAME_TALLY, tally[15:0], "tally one frame");
        pulse(0, TICKS * 6);
        pulse(0, 2);
        tally += 2;
        rd(IDX_FRAME_IVAL, 16'd6, "frame interval");
        wr(IDX_FRAME_TALLY, 16'h0000);
        rd(IDX_FRAME_TALLY, tally[15:0], "tally three frames");
        $display("Done: frame timing");
        v = $random(seed) & 16'h7fff;
        EMITTER_TEMP <= v;
        MAIN_TEMP <= ~v;
        EMITTER_TEMP_OK <= 1'b1;
        MAIN_TEMP_OK <= 1'b1;
        rd(IDX_EMIT_TEMP, v, "emitter temp");
        rd(IDX_MAIN_TEMP, ~v, "main temp");
        EMITTER_TEMP_OK <= 1'b0;
        MAIN_TEMP_OK <= 1'b0;
        rd(IDX_EMIT_TEMP, TEMP_ABSENT, "emitter absent");
        rd(IDX_MAIN_TEMP, TEMP_ABSENT, "main absent");
        wr(IDX_TEMP_LIMIT, 16'h1000);
        rd(IDX_TEMP_LIMIT, 16'h1000, "limit readback");
        for (int i = 0; i < 3; i++) begin
            @(posedge CLK);
            EMITTER_TEMP    <= (i == 1) ? 16'h1000 : 16'h1001;
            EMITTER_TEMP_OK <= (i != 2);
            settle(3);
            chk("over temperature", {32'h0, i == 0}, {32'h0, OVER_TEMP});
        end
        $display("Done: temperatures");
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            CAL_STATUS <= {v, codes[i][7:0], v[0], v[1], v[2]};
            rd(IDX_CAL_PROGRESS, {v[2], v[1], 1'b0, v[0], v[0], codes[i] >= 247, 2'b00,
                codes[i][7:0]}, "calibration progress");
            rd(IDX_CAL_TARGET, v, "calibration target");
        end
        wr(IDX_CAL_REQUEST, {8'h00, CAL_CMD_OFFSET});
        wr(IDX_CAL_REQUEST, 16'h0012);
        rd(IDX_CAL_REQUEST, 16'h0012, "cal request readback");
        settle(2);
        chk("calibration starts", 33'd1, cal_pulses);
        $display("Done: calibration");
        wr(IDX_CMD_EXEC, CMD_SAVE_MAP);
        wr(IDX_UNLOCK_KEY, KEY_FLASH_OPS);
        wr(IDX_CMD_EXEC, CMD_SAVE_MAP);
        wr(IDX_UNLOCK_KEY, KEY_TEST_CMDS);
        wr(IDX_CMD_EXEC, CMD_SAVE_MAP);
        settle(2);
        chk("flash saves", 33'd1, save_pulses);
        chk("test unlock", 33'd1, TEST_UNLOCK);
        $display("Done: unlock and save");
        @(posedge CLK);
        STORED_ILLUM_ALT <= 1'b0;
        RSTN <= 1'b0;
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (2) @(posedge CLK);
        rd(IDX_FEATURE, RST_FEATURE, "feature after reset");
        rd(IDX_LIN_AMP, RST_LIN_AMP, "linear after reset");
        chk("illumination", 33'd0, MODE.illum_alt);
        $display("Done: second reset");
        give_verdict();
    end
endmodule
`default_nettype wire
